// ---- bench/cppc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Host input behind the fault flag
// ----------------------------------------------------------------
// The host reads the flag through a pull-up, so a released pin is high.
module cppc_host_model (
  input wire logic fault_in,
  input wire logic fault_oe_n_in,
  output logic fault_line_out
);
  assign fault_line_out = fault_oe_n_in ? 1'b1 : fault_in;
endmodule

`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import cppc_pkg::*;
  localparam int PU = 50;
  localparam int BL = 20;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic good = 1'b0;
  logic en = 1'b1;
  cppc_trip_type trip = 5'h01;
  logic sw_on;
  logic [RAMP_W-1:0] gate;
  logic fault_d;
  logic fault_oe_n;
  logic fault_line;
  int err_count = 0;
  int comparisons = 0;

  cppc_top #(.POWERUP_CYC(PU), .BOVP_CYC(BL), .OC_CYC(BL), .STEP_CYC(1)) uut (
    .sys_clk_in(clk), .rst_in(rst), .supply_good_in(good), .enable_in(en),
    .trip_in(trip), .pass_switch_on_out(sw_on), .gate_drive_out(gate),
    .fault_out(fault_d), .fault_oe_n_out(fault_oe_n));

  cppc_host_model host (.fault_in(fault_d), .fault_oe_n_in(fault_oe_n),
    .fault_line_out(fault_line));

  initial
  begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_sw(input logic want, input int bound);
    for (int i = 0; i < bound && sw_on !== want; i++)
      step(1);
    check("switch wait", sw_on, want);
    if (sw_on !== want)
      conclude();
  endtask

  task automatic trip_event(input bit oc, input int len);
    if (oc)
      trip.overcurrent_trip = 1'b1;
    else
      trip.battery_overvoltage = 1'b1;
    step(len);
    trip.battery_overvoltage = 1'b0;
    trip.overcurrent_trip = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_powerup();
    logic [7:0] last;
    step(20);
    check("off before good", sw_on, 0);
    good = 1'b1;
    step(PU - 5);
    check("off in delay", sw_on, 0);
    wait_sw(1'b1, 20);
    check("ramp starts low", gate < 8'h10, 1);
    last = gate;
    repeat (300)
    begin
      step(1);
      check("ramp rising", gate >= last, 1);
      last = gate;
    end
    check("gate full", gate, RAMP_FULL);
    check("flag released", fault_line, 1);
  endtask

  task automatic sc_ovp();
    trip.overvoltage_trip = 1'b1;
    step(4);
    check("ovp off", sw_on, 0);
    check("ovp gate", gate, RAMP_ZERO);
    check("ovp flag", fault_line, 0);
    step(PU + 300);
    check("ovp held off", sw_on, 0);
    trip.overvoltage_trip = 1'b0;
    step(PU - 5);
    check("ovp redelay", sw_on, 0);
    wait_sw(1'b1, 20);
    check("ovp flag clear", fault_line, 1);
  endtask

  task automatic sc_thermal();
    trip.temp_above_hot = 1'b1;
    trip.temp_below_cool = 1'b0;
    step(5);
    check("hot off", sw_on, 0);
    check("hot flag", fault_line, 0);
    trip.temp_above_hot = 1'b0;
    step(PU + 20);
    check("warm held off", sw_on, 0);
    trip.temp_below_cool = 1'b1;
    wait_sw(1'b1, PU + 20);
  endtask

  // One event count per loop pass; only the last pass may latch.
  task automatic sc_counted(input bit oc, input int events);
    wait_sw(1'b1, PU + 20);
    trip_event(oc, BL - 5);
    step(2);
    trip_event(oc, BL - 5);
    step(5);
    check("blanked pulses", sw_on, 1);
    for (int n = 1; n <= events; n++)
    begin
      wait_sw(1'b1, PU + 20);
      trip_event(oc, BL + 6);
      check("event off", sw_on, 0);
      check("event flag", fault_line, 0);
      step(PU + 20);
      check("restart or latch", sw_on, n != events);
    end
    check("latch flag", fault_line, 0);
  endtask

  task automatic sc_power_cycle();
    good = 1'b0;
    step(5);
    trip.overcurrent_trip = 1'b1;
    step(BL + 10);
    check("oc ignored off", fault_line, 1);
    check("off without power", sw_on, 0);
    trip.overcurrent_trip = 1'b0;
    step(3);
    good = 1'b1;
    wait_sw(1'b1, PU + 20);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    step(5);
    rst = 1'b0;
    sc_powerup();
    sc_ovp();
    sc_thermal();
    sc_counted(1'b0, 16);
    sc_power_cycle();
    sc_counted(1'b1, 8);
    en = 1'b0;
    step(5);
    wait_sw(1'b1, PU + 20);
    check("flag after toggle", fault_line, 1);
    conclude();
  end
endmodule

`default_nettype wire

// ---- rtl/cppc_pkg.sv ----
package cppc_pkg;

  // ----------------------------------------------------------------
  // Timing figures and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int POWERUP_DELAY_MS = 10;
  localparam int BOVP_BLANK_US = 180;
  localparam int OC_DELAY_US = 170;
  localparam int OVP_RESPONSE_US = 1;
  localparam int RAMP_STEP_NS = 4000;
  localparam int POWERUP_DELAY_CYC = (POWERUP_DELAY_MS * 1000000) / CLK_PERIOD_NS;
  localparam int BOVP_BLANK_CYC = (BOVP_BLANK_US * 1000) / CLK_PERIOD_NS;
  localparam int OC_DELAY_CYC = (OC_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int OVP_RESPONSE_CYC = (OVP_RESPONSE_US * 1000) / CLK_PERIOD_NS;
  localparam int RAMP_STEP_CYC = (RAMP_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Event counting
  // ----------------------------------------------------------------
  localparam int EVENT_CNT_W = 4;
  localparam logic [3:0] BOVP_LAST_EVENT = 4'hf;
  localparam logic [3:0] OC_LAST_EVENT = 4'h7;
  localparam logic [3:0] EVENT_ZERO = 4'h0;
  localparam logic [3:0] EVENT_ONE = 4'h1;

  // ----------------------------------------------------------------
  // Soft-start ramp
  // ----------------------------------------------------------------
  localparam int RAMP_W = 8;
  localparam logic [7:0] RAMP_ZERO = 8'h00;
  localparam logic [7:0] RAMP_ONE = 8'h01;
  localparam logic [7:0] RAMP_FULL = 8'hff;

  // Comparator trips from the analog front end.
  typedef struct packed {
    logic overvoltage_trip;
    logic battery_overvoltage;
    logic overcurrent_trip;
    logic temp_above_hot;
    logic temp_below_cool;
  } cppc_trip_type;

  localparam int TRIP_W = 5;
  localparam int SYNC_W = TRIP_W + 2;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_DELAY = 4'h2,
    ST_RAMP = 4'h4,
    ST_ON = 4'h8
  } cppc_state_type;

endpackage

// ---- rtl/cppc_top.sv ----
`timescale 1ns/1ps
`default_nettype none

// Function
// RULE1: Fault flag pulled low while any protection condition is active.
// RULE2: Pass switch stays off while supply-good is not asserted.
// RULE3: Ten millisecond wait after supply-good, then reset state and soft-start.
// RULE4: Soft-start ramps the switch drive in small timed steps.
// RULE5: Input overvoltage turns the switch off within one microsecond, unfiltered.
// RULE6: When input overvoltage clears, delay and soft-start run again.
// RULE7: Switch never enables while input overvoltage persists, even during delay.
// RULE8: Battery overvoltage acts only after 180 microseconds of continuous assertion.
// RULE9: Sixteen confirmed battery overvoltage events latch the switch off permanently.
// RULE10: Losing input power clears counters and latches and restarts power-up.
// RULE11: Overcurrent is evaluated only while the pass switch is on.
// RULE12: Overcurrent acts only after persisting 170 microseconds, then switches off.
// RULE13: Eight overcurrent events latch off until power cycle or enable toggle.
// RULE14: Over-temperature switches off until the cool indication is seen.
// RULE15: All delays timed by counters on one clock, restarted on input drop.
// RULE16: Fault flag held low while either counting latch-off is set.
module cppc_top #(
  parameter int POWERUP_CYC = cppc_pkg::POWERUP_DELAY_CYC,
  parameter int BOVP_CYC = cppc_pkg::BOVP_BLANK_CYC,
  parameter int OC_CYC = cppc_pkg::OC_DELAY_CYC,
  parameter int STEP_CYC = cppc_pkg::RAMP_STEP_CYC
) (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic supply_good_in,
  input wire logic enable_in,
  input wire cppc_pkg::cppc_trip_type trip_in,
  output logic pass_switch_on_out,
  output logic [cppc_pkg::RAMP_W-1:0] gate_drive_out,
  output logic fault_out,
  output logic fault_oe_n_out
);
  import cppc_pkg::*;

  localparam int PU_W = $clog2(POWERUP_CYC + 1);
  localparam int BO_W = $clog2(BOVP_CYC + 1);
  localparam int OC_W = $clog2(OC_CYC + 1);
  localparam int ST_W = $clog2(STEP_CYC + 1);
  localparam logic [PU_W-1:0] PU_LAST = PU_W'(POWERUP_CYC - 1);
  localparam logic [BO_W-1:0] BO_LAST = BO_W'(BOVP_CYC - 1);
  localparam logic [OC_W-1:0] OC_LAST = OC_W'(OC_CYC - 1);
  localparam logic [ST_W-1:0] ST_LAST = ST_W'(STEP_CYC - 1);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_q;
  logic en_prev;
  cppc_trip_type trip_s;
  logic good_s;
  logic en_s;

  // The synchronisers carry no reset, so they already hold the pin levels when reset
  // ends and the enable edge detector never reports a false toggle at that moment.
  always_ff @(posedge sys_clk_in)
  begin
    sync_meta <= {supply_good_in, enable_in, trip_in};
    sync_q <= sync_meta;
  end

  assign trip_s = cppc_trip_type'(sync_q[TRIP_W-1:0]);
  assign en_s = sync_q[TRIP_W];
  assign good_s = sync_q[TRIP_W+1];

  always_ff @(posedge sys_clk_in)
  begin
    en_prev <= en_s;
  end

  logic en_toggle;
  logic power_clear;
  assign en_toggle = en_s ^ en_prev;
  // RULE10: power loss clears
  assign power_clear = rst_in | ~good_s;

  // ----------------------------------------------------------------
  // State and fault holds
  // ----------------------------------------------------------------
  cppc_state_type state;
  cppc_state_type next_state;
  logic [PU_W-1:0] pu_cnt;
  logic [BO_W-1:0] bo_cnt;
  logic [OC_W-1:0] oc_cnt;
  logic [ST_W-1:0] step_cnt;
  logic [RAMP_W-1:0] ramp;
  logic [EVENT_CNT_W-1:0] bovp_events;
  logic [EVENT_CNT_W-1:0] oc_events;
  logic bovp_hold;
  logic oc_hold;
  logic hot_hold;
  logic bovp_latch;
  logic oc_latch;
  logic bovp_pulse;
  logic oc_pulse;
  logic switch_live;
  logic blocked;
  logic any_fault;

  assign switch_live = (state == ST_RAMP) || (state == ST_ON);
  // RULE8: blanking confirms a battery event
  assign bovp_pulse = trip_s.battery_overvoltage & ~bovp_hold & (bo_cnt == BO_LAST);
  // RULE11: overcurrent only sensed while on
  assign oc_pulse = trip_s.overcurrent_trip & switch_live & ~oc_hold & (oc_cnt == OC_LAST);
  // RULE1: any protection condition
  assign any_fault = trip_s.overvoltage_trip | bovp_hold | oc_hold | hot_hold
    | bovp_latch | oc_latch;
  // RULE7: overvoltage blocks delay and ramp
  assign blocked = ~good_s | any_fault | bovp_pulse | oc_pulse;

  // RULE15: battery blanking timer restarts on drop
  always_ff @(posedge sys_clk_in)
  begin
    if (power_clear || !trip_s.battery_overvoltage || bovp_hold)
      bo_cnt <= '0;
    else if (bo_cnt != BO_LAST)
      bo_cnt <= bo_cnt + BO_W'(1);
  end

  // RULE12: overcurrent delay filter
  always_ff @(posedge sys_clk_in)
  begin
    if (power_clear || !trip_s.overcurrent_trip || !switch_live || oc_hold)
      oc_cnt <= '0;
    else if (oc_cnt != OC_LAST)
      oc_cnt <= oc_cnt + OC_W'(1);
  end

  // The set term is tested before the comparator clear so an event never loses to it; power_clear wins over both.
  always_ff @(posedge sys_clk_in)
  begin
    if (power_clear)
      bovp_hold <= 1'b0;
    else if (bovp_pulse)
      bovp_hold <= 1'b1;
    else if (!trip_s.battery_overvoltage)
      bovp_hold <= 1'b0;
  end

  // The switch is off once this holds, so the comparator falls and releases it.
  always_ff @(posedge sys_clk_in)
  begin
    if (power_clear)
      oc_hold <= 1'b0;
    else if (oc_pulse)
      oc_hold <= 1'b1;
    else if (!trip_s.overcurrent_trip)
      oc_hold <= 1'b0;
  end

  // RULE14: thermal hysteresis hold
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      hot_hold <= 1'b0;
    else if (trip_s.temp_above_hot)
      hot_hold <= 1'b1;
    else if (trip_s.temp_below_cool)
      hot_hold <= 1'b0;
  end

  // RULE9: sixteenth battery event latches
  always_ff @(posedge sys_clk_in)
  begin
    if (power_clear)
    begin
      bovp_events <= EVENT_ZERO;
      bovp_latch <= 1'b0;
    end
    else if (bovp_pulse)
    begin
      bovp_events <= bovp_events + EVENT_ONE;
      if (bovp_events == BOVP_LAST_EVENT)
        bovp_latch <= 1'b1;
    end
  end

  // RULE13: eighth overcurrent event latches
  always_ff @(posedge sys_clk_in)
  begin
    if (power_clear)
    begin
      oc_events <= EVENT_ZERO;
      oc_latch <= 1'b0;
    end
    else if (oc_pulse)
    begin
      oc_events <= oc_events + EVENT_ONE;
      if (oc_events == OC_LAST_EVENT)
        oc_latch <= 1'b1;
    end
    else if (en_toggle)
    begin
      oc_events <= EVENT_ZERO;
      oc_latch <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power-up sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    // RULE2: off without supply-good
    if (blocked)
      next_state = ST_OFF;
    else
    begin
      unique case (state)
        // RULE6: clear fault restarts delay
        ST_OFF: next_state = ST_DELAY;
        // RULE3: delay expiry starts ramp
        ST_DELAY: if (pu_cnt == PU_LAST) next_state = ST_RAMP;
        ST_RAMP: if (ramp == RAMP_FULL) next_state = ST_ON;
        ST_ON: next_state = ST_ON;
        default: next_state = ST_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
      state <= ST_OFF;
    else
      state <= next_state;
  end

  // RULE15: power-up delay counter
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || state != ST_DELAY || blocked)
      pu_cnt <= '0;
    else if (pu_cnt != PU_LAST)
      pu_cnt <= pu_cnt + PU_W'(1);
  end

  // RULE4: stepped ramp
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || state != ST_RAMP || blocked)
      step_cnt <= '0;
    else if (step_cnt == ST_LAST)
      step_cnt <= '0;
    else
      step_cnt <= step_cnt + ST_W'(1);
  end

  // RULE5: drive falls at once on any block
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in || blocked || !switch_live)
      ramp <= RAMP_ZERO;
    else if (state == ST_RAMP && step_cnt == ST_LAST && ramp != RAMP_FULL)
      ramp <= ramp + RAMP_ONE;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      pass_switch_on_out <= 1'b0;
      gate_drive_out <= RAMP_ZERO;
    end
    else
    begin
      pass_switch_on_out <= switch_live & ~blocked;
      gate_drive_out <= blocked ? RAMP_ZERO : ramp;
    end
  end

  // RULE16: latches keep the flag driven
  always_ff @(posedge sys_clk_in)
  begin
    fault_out <= 1'b0;
    if (rst_in)
      fault_oe_n_out <= 1'b1;
    else
      fault_oe_n_out <= ~(any_fault | bovp_pulse | oc_pulse);
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  a_ovp_fast_off: assert property (trip_s.overvoltage_trip |=> !pass_switch_on_out && gate_drive_out == RAMP_ZERO) else $error("switch on during overvoltage"); // RULE5
  a_por_hold_off: assert property (!good_s |=> !pass_switch_on_out) else $error("switch on without supply-good"); // RULE2
  a_delay_length: assert property ($rose(state == ST_RAMP) |-> $past(state) == ST_DELAY && $past(pu_cnt) == PU_LAST) else $error("ramp began before delay expired"); // RULE3
  a_ramp_steps: assert property (gate_drive_out == $past(gate_drive_out) || gate_drive_out == $past(gate_drive_out) + RAMP_ONE || gate_drive_out == RAMP_ZERO) else $error("drive jumped"); // RULE4
  a_ovp_no_enable: assert property (trip_s.overvoltage_trip |-> state == ST_OFF || $past(trip_s.overvoltage_trip) == 1'b0) else $error("sequencer ran during overvoltage"); // RULE7
  a_bovp_blanking: assert property ($rose(bovp_hold) |-> $past(bo_cnt) == BO_LAST && $past(trip_s.battery_overvoltage)) else $error("battery trip before blanking"); // RULE8
  a_bovp_latch: assert property (bovp_pulse && bovp_events == BOVP_LAST_EVENT && good_s |=> bovp_latch) else $error("no latch on sixteenth event"); // RULE9
  a_power_clear: assert property (!good_s |=> !bovp_latch && !oc_latch && bovp_events == EVENT_ZERO) else $error("power loss did not clear"); // RULE10
  a_oc_when_on: assert property (oc_pulse |-> $past(switch_live)) else $error("overcurrent while switch off"); // RULE11
  a_oc_latch: assert property (oc_pulse && oc_events == OC_LAST_EVENT && good_s |=> oc_latch) else $error("no latch on eighth overcurrent"); // RULE13
  a_temp_off: assert property (hot_hold |=> !pass_switch_on_out) else $error("switch on while hot"); // RULE14
  a_latch_flag: assert property ((bovp_latch || oc_latch) |=> !fault_oe_n_out) else $error("flag released while latched"); // RULE16
  a_flag_release: assert property (!blocked [*2] |-> fault_oe_n_out) else $error("flag held without fault"); // RULE1
  a_flag_on_fault: assert property (any_fault |=> !fault_oe_n_out) else $error("flag released during fault"); // RULE1

  c_reach_on: cover property (state == ST_RAMP ##1 state == ST_ON);
  c_bovp_lock: cover property ($rose(bovp_latch));
  c_oc_lock: cover property ($rose(oc_latch));
  c_ovp_trip: cover property (state == ST_ON ##1 trip_s.overvoltage_trip);

endmodule

`default_nettype wire
